/* verilog/sar_readout_cfg.svh */
// constants for the four-wire readout block
`ifndef SAR_READOUT_CFG_SVH
`define SAR_READOUT_CFG_SVH

`define RESULT_BITS 16
`define STATUS_BITS 6
`define FRAME_BITS 22
`define STATUS_FAST_BIT 2
// conversion time in ns; plain default, not a characterised figure
`define CONV_TIME_NS 290
`define CLK_PERIOD_PS 4000
// longest time rounds down, never below one cycle
`define CONV_CYCLES (((`CONV_TIME_NS * 1000) / `CLK_PERIOD_PS) < 1 ? 1 : \
  ((`CONV_TIME_NS * 1000) / `CLK_PERIOD_PS))
`define CONV_COUNT_BITS 12
`define PIN_COUNT 3
`define PIN_CONV 0
`define PIN_SEL 1
`define PIN_SCLK 2

`endif

/* verilog/sar_readout_pkg.sv */
// types shared by the readout block
package sar_readout_pkg;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_PUSH = 2'b10
  } conv_state_type;

  typedef enum logic [1:0] {
    READ_OFF = 2'b00,
    READ_ARMED = 2'b01,
    READ_BUSYLOW = 2'b10,
    READ_SHIFT = 2'b11
  } read_state_type;

  typedef enum logic [1:0] {
    MODE_FAST = 2'b00,
    MODE_NOBUSY = 2'b01,
    MODE_BUSY = 2'b10
  } read_mode_type;

endpackage

/* verilog/word_stream_if.sv */
// valid/ready word stream between the block's own modules
`timescale 1ns/1ps
`default_nettype none

interface word_stream_if #(parameter int WIDTH = 16);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

`default_nettype wire

/* verilog/pin_sync.sv */
// two-flop synchronisers for asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk, // sampling clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic [WIDTH-1:0] pinIn, // raw pins
  output logic [WIDTH-1:0] pinOut // synchronised levels
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      logic stage2;
      always_ff @(posedge clk) begin
        if (!rstn) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= pinIn[i];
          stage2 <= stage1;
        end
      end
      assign pinOut[i] = stage2;
    end
  endgenerate
endmodule

`default_nettype wire

/* verilog/two_entry_buffer.sv */
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk, // block clock
  input wire logic rstn, // synchronous reset, active low
  word_stream_if.sink fill, // writer side
  word_stream_if.source drain // reader side
);
  logic [WIDTH-1:0] store [DEPTH];
  logic [$clog2(DEPTH)-1:0] wrIdx, rdIdx, next_wrIdx, next_rdIdx;
  logic [$clog2(DEPTH+1)-1:0] count, next_count;
  logic pushFire, popFire;

  assign fill.ready = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign drain.valid = (count != '0);
  assign drain.data = store[rdIdx];
  assign pushFire = fill.valid && fill.ready;
  assign popFire = drain.valid && drain.ready;

  always_comb begin
    next_wrIdx = wrIdx;
    next_rdIdx = rdIdx;
    next_count = count;
    if (pushFire) begin
      next_wrIdx = (wrIdx == DEPTH[$clog2(DEPTH)-1:0] - 1'b1) ? '0 : wrIdx + 1'b1;
    end
    if (popFire) begin
      next_rdIdx = (rdIdx == DEPTH[$clog2(DEPTH)-1:0] - 1'b1) ? '0 : rdIdx + 1'b1;
    end
    if (pushFire && !popFire) begin
      next_count = count + 1'b1;
    end else if (popFire && !pushFire) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrIdx <= '0;
      rdIdx <= '0;
      count <= '0;
    end else begin
      wrIdx <= next_wrIdx;
      rdIdx <= next_rdIdx;
      count <= next_count;
      if (pushFire) begin
        store[wrIdx] <= fill.data;
      end
    end
  end
endmodule

`default_nettype wire

/* verilog/sar_adc_four_wire_readout.sv */
// conversion control and four-wire serial readout
// Functional notes
// - conversion-start rise begins a conversion and floats the serial output at once
// - fast-readout enable at 1 selects fast mode instead of busy-indicator mode
// - fast mode shifts out the previous conversion's result
// - select low shows the result MSB, then one bit per serial-clock fall
// - result occupies the first 16 serial-clock falls of a readback
// - with status enabled, six status bits follow the result bits
// - fast mode floats output after the last fall or conversion-start rise
// - the two other modes need fast-readout enable at 0, its default
// - finished conversion enters acquisition and powers conversion logic down
// - no-busy mode floats output after the last fall or select going high
// - busy mode drives the output low at conversion end as an interrupt
// - busy mode shifts the result MSB first on following serial-clock falls
// - busy mode floats output after an extra fall or conversion-start rise
// - each bit stays valid across both serial-clock edges
// - status bit 2 mirrors the fast-readout enable field
`timescale 1ns/1ps
`default_nettype none
`include "sar_readout_cfg.svh"

module sar_adc_four_wire_readout (
  input wire logic ref_clk, // 250 MHz block clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic convStartPin, // conversion-start pin, asynchronous
  input wire logic selectPin, // select/serial-in pin, asynchronous
  input wire logic serialClkPin, // serial clock pin, asynchronous
  input wire logic fastReadoutEnable, // configuration field, same clock
  input wire logic statusEnable, // status bits appended when high
  input wire logic [2:0] statusHigh, // status bits 5..3 from configuration
  input wire logic [`RESULT_BITS-1:0] sampleCode, // front-end code, same clock
  output logic serialOut, // serial result data
  output logic serialOutEnable, // high while the output pin is driven
  output logic conversionActive // high while conversion logic is powered
);
  import sar_readout_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  logic [`PIN_COUNT-1:0] pinsRaw, pinsSync, pinsPrev;
  logic convLevel, selLevel, convRise, selFall, sclkFall;

  assign pinsRaw = {serialClkPin, selectPin, convStartPin};

  pin_sync #(
    .WIDTH(`PIN_COUNT)
  ) u_sync (
    .clk(ref_clk),
    .rstn(rstn),
    .pinIn(pinsRaw),
    .pinOut(pinsSync)
  );

  // previous level so edges are taken from the second stage only
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pinsPrev <= '0;
    end else begin
      pinsPrev <= pinsSync;
    end
  end

  assign convLevel = pinsSync[`PIN_CONV];
  assign selLevel = pinsSync[`PIN_SEL];
  assign convRise = pinsSync[`PIN_CONV] && !pinsPrev[`PIN_CONV];
  assign selFall = !pinsSync[`PIN_SEL] && pinsPrev[`PIN_SEL];
  assign sclkFall = !pinsSync[`PIN_SCLK] && pinsPrev[`PIN_SCLK];

  ////////////////////////////////////////////////////////////////////////
  // result buffer between conversion and readout

  word_stream_if #(.WIDTH(`RESULT_BITS)) convWords ();
  word_stream_if #(.WIDTH(`RESULT_BITS)) readWords ();

  two_entry_buffer #(
    .WIDTH(`RESULT_BITS),
    .DEPTH(2)
  ) u_buffer (
    .clk(ref_clk),
    .rstn(rstn),
    .fill(convWords.sink),
    .drain(readWords.source)
  );

  ////////////////////////////////////////////////////////////////////////
  // conversion timer

  conv_state_type convState, next_convState;
  logic [`CONV_COUNT_BITS-1:0] convCount, next_convCount;
  logic [`RESULT_BITS-1:0] sampled, next_sampled;
  logic pushValid, next_pushValid;
  logic next_conversionActive;

  assign convWords.valid = pushValid;
  assign convWords.data = sampled;

  always_comb begin
    next_convState = convState;
    next_convCount = convCount;
    next_sampled = sampled;
    next_pushValid = pushValid;
    next_conversionActive = conversionActive;
    case (convState)
      CONV_IDLE: begin
        if (convRise) begin
          next_convState = CONV_RUN;
          next_convCount = `CONV_COUNT_BITS'(`CONV_CYCLES - 1);
          next_sampled = sampleCode;
          next_conversionActive = 1'b1;
        end
      end
      CONV_RUN: begin
        // runs to completion whatever the pins do meanwhile
        if (convCount == '0) begin
          next_convState = CONV_PUSH;
          next_pushValid = 1'b1;
        end else begin
          next_convCount = convCount - 1'b1;
        end
      end
      CONV_PUSH: begin
        // a full buffer stalls here rather than losing the word
        if (pushValid && convWords.ready) begin
          next_pushValid = 1'b0;
          next_convState = CONV_IDLE;
          next_conversionActive = 1'b0;
        end
      end
      default: begin
        next_convState = CONV_IDLE;
        next_pushValid = 1'b0;
        next_conversionActive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      convState <= CONV_IDLE;
      convCount <= '0;
      sampled <= '0;
      pushValid <= 1'b0;
      conversionActive <= 1'b0;
    end else begin
      convState <= next_convState;
      convCount <= next_convCount;
      sampled <= next_sampled;
      pushValid <= next_pushValid;
      conversionActive <= next_conversionActive;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readout shifter

  read_state_type readState, next_readState;
  read_mode_type readMode, next_readMode;
  logic [`RESULT_BITS-1:0] held, next_held;
  logic [`FRAME_BITS-1:0] frame, next_frame;
  logic [4:0] bitIdx, next_bitIdx;
  logic [4:0] frameLen, next_frameLen;
  logic [4:0] nextIdx;
  logic next_serialOut, next_serialOutEnable;
  logic popFire;
  logic [`STATUS_BITS-1:0] statusWord;

  // status field: bit 2 mirrors the fast-readout field, 1..0 reserved
  assign statusWord = {statusHigh, fastReadoutEnable, 2'b00};
  // new words are taken only between readbacks so a frame never changes
  assign readWords.ready = (readState == READ_OFF) || (readState == READ_ARMED);
  assign popFire = readWords.valid && readWords.ready;
  assign nextIdx = bitIdx + 5'h01;

  always_comb begin
    next_readState = readState;
    next_readMode = readMode;
    next_held = held;
    next_frame = frame;
    next_bitIdx = bitIdx;
    next_frameLen = frameLen;
    next_serialOut = serialOut;
    next_serialOutEnable = serialOutEnable;
    if (popFire) begin
      next_held = readWords.data;
    end
    if (convRise) begin
      // any readback still open ends here
      next_readState = READ_OFF;
      next_serialOutEnable = 1'b0;
    end else begin
      case (readState)
        READ_OFF, READ_ARMED: begin
          if (fastReadoutEnable) begin
            if (selFall && convLevel) begin
              // held is the word from the conversion before this one
              next_frame = {held, statusWord};
              next_frameLen = statusEnable ? 5'(`FRAME_BITS) : 5'(`RESULT_BITS);
              next_bitIdx = 5'h00;
              next_serialOut = held[`RESULT_BITS-1];
              next_serialOutEnable = 1'b1;
              next_readMode = MODE_FAST;
              next_readState = READ_SHIFT;
            end
          end else if (popFire) begin
            next_frame = {readWords.data, statusWord};
            next_frameLen = statusEnable ? 5'(`FRAME_BITS) : 5'(`RESULT_BITS);
            next_bitIdx = 5'h00;
            if (!selLevel) begin
              // select low at completion means the host wants the busy edge
              next_serialOut = 1'b0;
              next_serialOutEnable = 1'b1;
              next_readMode = MODE_BUSY;
              next_readState = READ_BUSYLOW;
            end else begin
              next_readMode = MODE_NOBUSY;
              next_readState = READ_ARMED;
            end
          end else if (readState == READ_ARMED && selFall) begin
            next_serialOut = frame[`FRAME_BITS-1];
            next_serialOutEnable = 1'b1;
            next_bitIdx = 5'h00;
            next_readState = READ_SHIFT;
          end
        end
        READ_BUSYLOW: begin
          if (sclkFall) begin
            next_serialOut = frame[`FRAME_BITS-1];
            next_bitIdx = 5'h00;
            next_readState = READ_SHIFT;
          end
        end
        READ_SHIFT: begin
          if (readMode == MODE_NOBUSY && selLevel) begin
            // frame kept armed so a later select restarts at the top bit
            next_serialOutEnable = 1'b0;
            next_readState = READ_ARMED;
          end else if (sclkFall) begin
            // bit changes only on falls, so it holds across the rise
            if (nextIdx == frameLen) begin
              next_serialOutEnable = 1'b0;
              next_readState = READ_OFF;
            end else begin
              next_bitIdx = nextIdx;
              next_serialOut = frame[5'(`FRAME_BITS - 1) - nextIdx];
            end
          end
        end
        default: begin
          next_readState = READ_OFF;
          next_serialOutEnable = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      readState <= READ_OFF;
      readMode <= MODE_NOBUSY;
      held <= '0;
      frame <= '0;
      bitIdx <= '0;
      frameLen <= 5'(`RESULT_BITS);
      serialOut <= 1'b0;
      serialOutEnable <= 1'b0;
    end else begin
      readState <= next_readState;
      readMode <= next_readMode;
      held <= next_held;
      frame <= next_frame;
      bitIdx <= next_bitIdx;
      frameLen <= next_frameLen;
      serialOut <= next_serialOut;
      serialOutEnable <= next_serialOutEnable;
    end
  end

endmodule

`default_nettype wire

/* verif/sar_readout_props.sv */
// concurrent checks on the readout block's ports
`timescale 1ns/1ps
`default_nettype none

module sar_readout_props (
  input wire logic ref_clk, // block clock
  input wire logic rstn, // reset, active low
  input wire logic convStartPin, // conversion start pin
  input wire logic selectPin, // select pin, low selects
  input wire logic serialClkPin, // serial clock pin
  input wire logic fastReadoutEnable, // fast mode field
  input wire logic serialOut, // serial data
  input wire logic serialOutEnable, // output enable
  input wire logic conversionActive // conversion logic powered
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // pins pass two sync flops and an edge detector, hence the slack of six
  sequence s_start;
    $rose(convStartPin);
  endsequence
  sequence s_floats;
    ##[1:6] !serialOutEnable;
  endsequence
  property p_bit_stands;
    serialClkPin && $past(serialClkPin, 5) && serialOutEnable && $past(serialOutEnable) |-> $stable(serialOut);
  endproperty
  property p_select_drives;
    $fell(selectPin) && convStartPin && !conversionActive && !fastReadoutEnable |-> ##[1:6] serialOutEnable;
  endproperty
  property p_busy_irq;
    $fell(conversionActive) && !selectPin && !fastReadoutEnable |-> ##[0:6] (serialOutEnable && !serialOut);
  endproperty

  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !serialOutEnable && !conversionActive)
    else $error("outputs active during reset");
  a_start_floats: assert property (s_start |-> s_floats)
    else $error("output still driven after conversion start");
  a_start_begins: assert property ($rose(convStartPin) && !conversionActive |-> ##[1:6] conversionActive)
    else $error("conversion did not begin");
  a_conv_powerdown: assert property ($rose(conversionActive) |=> conversionActive[*8] ##[1:1000] !conversionActive)
    else $error("conversion logic not powered down in time");
  a_bit_stands: assert property (p_bit_stands)
    else $error("data moved while serial clock high");
  a_select_floats: assert property (!fastReadoutEnable && $rose(selectPin) |-> s_floats)
    else $error("output driven after deselect");
  a_select_drives: assert property (p_select_drives)
    else $error("select low did not drive output");
  a_busy_irq: assert property (p_busy_irq)
    else $error("no low completion level in busy mode");
endmodule

`default_nettype wire

bind sar_adc_four_wire_readout sar_readout_props u_props (.ref_clk(ref_clk), .rstn(rstn),
  .convStartPin(convStartPin), .selectPin(selectPin), .serialClkPin(serialClkPin),
  .fastReadoutEnable(fastReadoutEnable), .serialOut(serialOut), .serialOutEnable(serialOutEnable),
  .conversionActive(conversionActive));

/* verif/sar_host_model.sv */
// host model driving conversion start, select and serial clock
`timescale 1ns/1ps
`default_nettype none

module sar_host_model (
  output logic convStartPin, // conversion start
  output logic selectPin, // select, low selects
  output logic serialClkPin, // serial clock, still between frames
  input wire logic serialOut, // device data
  input wire logic serialOutEnable, // device drives the line
  output wire logic line // level on the shared wire
);
  // pull-up holds the wire high while released, so a stale bit never shows
  assign line = serialOutEnable ? serialOut : 1'b1;

  initial begin
    idle();
  end

  task automatic idle();
    convStartPin = 1'b0;
    selectPin = 1'b1;
    serialClkPin = 1'b0;
  endtask

  task automatic start();
    #100;
    selectPin = 1'b1;
    convStartPin = 1'b0;
    #40;
    convStartPin = 1'b1;
    #40;
  endtask

  task automatic select(input logic lvl);
    selectPin = lvl;
    #40;
  endtask

  // early samples in the high phase, late ones after the fall; 125 ns period
  task automatic shift(input int n, input logic late, output logic [21:0] bits);
    bits = '0;
    for (int k = 0; k < n; k++) begin
      serialClkPin = 1'b1;
      #62.5;
      if (!late) bits = {bits[20:0], line};
      serialClkPin = 1'b0;
      #62.5;
      if (late) bits = {bits[20:0], line};
    end
    #40;
  endtask
endmodule

`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the four-wire readout block
`timescale 1ns/1ps
`default_nettype none
`include "sar_readout_cfg.svh"

module testbench;
  logic ref_clk, rstn, fastReadoutEnable, statusEnable;
  logic [2:0] statusHigh;
  logic [`RESULT_BITS-1:0] sampleCode;
  logic convStartPin, selectPin, serialClkPin, serialOut, serialOutEnable, conversionActive, line;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [21:0] got;

  sar_adc_four_wire_readout dut (.ref_clk(ref_clk), .rstn(rstn), .convStartPin(convStartPin),
    .selectPin(selectPin), .serialClkPin(serialClkPin), .fastReadoutEnable(fastReadoutEnable),
    .statusEnable(statusEnable), .statusHigh(statusHigh), .sampleCode(sampleCode), .serialOut(serialOut),
    .serialOutEnable(serialOutEnable), .conversionActive(conversionActive));
  sar_host_model host (.convStartPin(convStartPin), .selectPin(selectPin), .serialClkPin(serialClkPin),
    .serialOut(serialOut), .serialOutEnable(serialOutEnable), .line(line));

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] seen);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [21:0] frame(input logic [15:0] code);
    return statusEnable ? {code, statusHigh, fastReadoutEnable, 2'b00} : {6'h00, code};
  endfunction

  task automatic do_reset();
    host.idle();
    @(posedge ref_clk);
    #1 rstn = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 rstn = 1'b1;
  endtask

  task automatic cfg(input logic f, input logic s, input logic [15:0] c);
    @(posedge ref_clk);
    #1;
    fastReadoutEnable = f;
    statusEnable = s;
    statusHigh = c[2:0];
    sampleCode = c;
  endtask

  task automatic wait_conv();
    chk("active", 1, conversionActive);
    for (int i = 0; i < 300 && conversionActive !== 1'b0; i++) @(posedge ref_clk);
    #1 chk("active", 0, conversionActive);
  endtask

  task automatic t_fast(input logic [15:0] a, input logic [15:0] b);
    cfg(1'b1, 1'b1, a);
    host.start();
    #60;
    host.select(1'b0);
    host.shift(22, 1'b0, got);
    chk("frame", frame(16'h0000), got);
    chk("released", 0, serialOutEnable);
    host.select(1'b1);
    cfg(1'b1, 1'b1, b);
    host.start();
    #60;
    host.select(1'b0);
    host.shift(5, 1'b0, got);
    chk("frame", {17'h00000, a[15:11]}, got);
    host.select(1'b1);
    chk("held", 1, serialOutEnable);
    host.start();
    chk("released", 0, serialOutEnable);
  endtask

  task automatic t_nobusy(input logic s, input logic [15:0] c);
    cfg(1'b0, s, c);
    host.start();
    chk("float", 0, serialOutEnable);
    wait_conv();
    host.select(1'b0);
    chk("drive", 1, serialOutEnable);
    host.shift(s ? 22 : 16, 1'b0, got);
    chk("frame", frame(c), got);
    chk("released", 0, serialOutEnable);
    chk("line", 1, line);
    host.select(1'b1);
  endtask

  task automatic t_busy(input logic [15:0] c);
    cfg(1'b0, 1'b1, c);
    host.start();
    host.select(1'b0);
    wait_conv();
    #20 chk("irq", 0, line);
    host.shift(22, 1'b1, got);
    chk("frame", frame(c), got);
    chk("held", 1, serialOutEnable);
    host.shift(1, 1'b1, got);
    chk("released", 0, serialOutEnable);
    host.select(1'b1);
  endtask

  // partial read then a fresh select must start over at the top bit
  task automatic t_restart(input logic [15:0] c);
    cfg(1'b0, 1'b0, c);
    host.start();
    wait_conv();
    host.select(1'b0);
    host.shift(5, 1'b0, got);
    host.select(1'b1);
    chk("released", 0, serialOutEnable);
    host.select(1'b0);
    chk("drive", 1, serialOutEnable);
    host.shift(16, 1'b0, got);
    chk("frame", frame(c), got);
    host.select(1'b1);
  endtask

  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    fastReadoutEnable = 1'b0;
    statusEnable = 1'b0;
    statusHigh = 3'h0;
    sampleCode = 16'h0000;
    do_reset();
    t_fast(16'hc3a5, 16'h5a1e);
    do_reset();
    t_nobusy(1'b0, 16'h8001);
    t_nobusy(1'b1, 16'h7ffe);
    t_busy(16'ha5c3);
    t_restart(16'h1234);
    test_done();
  end
endmodule

`default_nettype wire
